// >>> include/otg_rx_pkg.sv
// Constants for the USB channel, receive status and IN token block
// Function
// - Channel enable queues IN request
// - IN token waits for current OUT
// - Receive level irq after packet written
// - Transfer complete raised when status popped
// - Disable write queues channel disable request
// - Receive level irq after halt entry written
// - Channel halted raised when halt popped
// - Empty FIFO IN token: NAK, flag
// - Loaded FIFO IN token: send, await ACK
// - Device entry carries frame bits 24:21
// - Data PID field reports received PID
// - Eleven bit byte count field
// - Four bit channel or endpoint field
// - Ten bit FIFO depth, reset default
// - Summary read before channel flags
// - Clearing channel flag clears summaries
// - Error flags hardware set, write-one clear
// - Transaction error on CRC/timeout/stuff/EOP
// - ACK NAK STALL bus flags write-one clear
package otg_rx_pkg;
    // Register byte addresses
    localparam logic [17:0] A_CORE_IRQ = 18'h3c014;
    localparam logic [17:0] A_PEEK     = 18'h3c01c;
    localparam logic [17:0] A_POP      = 18'h3c020;
    localparam logic [17:0] A_RXFSIZE  = 18'h3c024;
    localparam logic [17:0] A_ALLCH    = 18'h3c414;
    localparam logic [17:0] A_HCCHAR   = 18'h3c500;
    localparam logic [17:0] A_HCINT    = 18'h3c508;
    localparam logic [17:0] A_EPFLAGS  = 18'h3c908;
    // Reset values
    localparam logic [9:0] RXDEP_RST = 10'h200;
    // Status entry fields
    localparam int FN_LO = 21;
    localparam int PS_LO = 17;
    localparam int PID_LO = 15;
    localparam int BC_LO = 4;
    // Packet status codes
    localparam logic [3:0] PS_GLOBAL_OUT_NAK_STATUS = 4'h1;
    localparam logic [3:0] PS_PKT     = 4'h2;
    localparam logic [3:0] PS_XFER    = 4'h3;
    localparam logic [3:0] PS_SETUP   = 4'h4;
    localparam logic [3:0] PS_TGL     = 4'h5;
    localparam logic [3:0] PS_SETDATA = 4'h6;
    localparam logic [3:0] PS_HALT    = 4'h7;
    // Channel flag bits
    localparam int F_XFER = 0;
    localparam int F_HALT = 1;
    localparam int F_BUS  = 2;
    localparam int F_STALL = 3;
    localparam int F_NAK  = 4;
    localparam int F_ACK  = 5;
    localparam int F_XACT = 7;
    localparam int F_BBL  = 8;
    localparam int F_FOVR = 9;
    localparam int F_TGL  = 10;
    localparam logic [10:0] F_MASK = 11'h7bf;
    // Characteristics bits
    localparam int C_EN = 31;
    localparam int C_DIS = 30;
    localparam int C_EP_LO = 11;
    // Core summary bits
    localparam int G_RX_FIFO_LEVEL_IRQ = 4;
    localparam int G_HCH = 25;
    // Request kinds
    localparam logic REQ_IN  = 1'b0;
    localparam logic REQ_DIS = 1'b1;
endpackage

// >>> logic/otg_rx_channel.sv
// Host channel queue, receive status FIFO and device IN token logic
`timescale 1ns/1ps
`default_nettype none
module otg_rx_channel #(
    parameter int RQ_DEPTH = 4,  // Request queue entries
    parameter int RX_WORDS = 8   // Receive status entries held
) (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Mode
    input  wire logic        host_mode,
    // Host link side
    input  wire logic        out_busy,
    output logic             in_token_issue,
    output logic             chan_disable_issue,
    input  wire logic        rx_wr,
    input  wire logic [3:0]  rx_status,
    input  wire logic [1:0]  rx_pid,
    input  wire logic [10:0] rx_byte_count_field,
    input  wire logic [3:0]  rx_id,
    input  wire logic [3:0]  rx_frame,
    input  wire logic        ev_ack,
    input  wire logic        ev_nak,
    input  wire logic        ev_stall,
    input  wire logic        ev_bus_err,
    input  wire logic        ev_crc_err,
    input  wire logic        ev_timeout,
    input  wire logic        ev_stuff_err,
    input  wire logic        ev_false_eop,
    input  wire logic        ev_babble,
    input  wire logic        ev_frame_ovr,
    input  wire logic        ev_toggle,
    // Device IN token side
    input  wire logic        dev_in_token,
    input  wire logic [3:0]  dev_in_ep,
    input  wire logic [15:0] txf_has_data,
    input  wire logic        dev_host_ack,
    output logic             dev_nak,
    output logic             dev_send,
    output logic             dev_wait_ack,
    // Summary outputs
    output logic             rx_fifo_level_irq,
    output logic             host_channels_summary_irq
);
    import otg_rx_pkg::*;

    localparam int RQW = $clog2(RQ_DEPTH);
    localparam int RXW = $clog2(RX_WORDS);

    // Device IN token handler states
    typedef enum logic [1:0] {
        D_IDLE = 2'b01,
        D_WAIT = 2'b10
    } dev_e;

    // Whole block state
    typedef struct packed {
        logic [RQ_DEPTH-1:0]        rq;
        logic [RQW-1:0]             rq_rd;
        logic [RQW-1:0]             rq_wr;
        logic [RQW:0]               rq_cnt;
        logic [RX_WORDS-1:0][31:0]  rx;
        logic [RXW-1:0]             rx_rd;
        logic [RXW-1:0]             rx_wr;
        logic [RXW:0]               rx_cnt;
        logic [9:0]                 rx_depth;
        logic [31:0]                chr;
        logic [10:0]                flags;
        logic [15:0]                ep_flags;
        logic                       halt_pend;
        dev_e                       dst;
        logic [31:0]                rdata;
        logic                       rd_pop_ok;
        logic                       slverr;
        logic                       tok;
        logic                       dis;
        logic                       nak;
        logic                       snd;
    } state_s;

    state_s s_q;   // Registered state
    state_s s_d;   // Next state

    // Address decode, shared by setup and access phases
    function automatic logic mapped(input logic [17:0] a);
        return a == A_CORE_IRQ || a == A_PEEK || a == A_POP ||
               a == A_RXFSIZE || a == A_ALLCH || a == A_HCCHAR ||
               a == A_HCINT || a == A_EPFLAGS;
    endfunction

    // Status entry assembly from the receive side fields
    function automatic logic [31:0] entry(input logic [3:0] st,
            input logic [1:0] pid, input logic [10:0] bc,
            input logic [3:0] id, input logic [3:0] fn);
        logic [31:0] e;
        e = '0;
        e[FN_LO +: 4] = fn;
        e[PS_LO +: 4] = st;
        e[PID_LO +: 2] = pid;
        e[BC_LO +: 11] = bc;
        e[3:0] = id;
        return e;
    endfunction

    logic        setup_ph;   // APB setup cycle
    logic        acc_ph;     // APB access cycle
    logic        wr_acc;     // Write takes effect
    logic        rx_full;    // No room for a status entry
    logic [31:0] head;       // Oldest status entry
    logic [3:0]  head_st;    // Its status code
    logic        xact_ev;    // Any transaction error cause
    logic        rx_nonempty;// FIFO holds entries

    assign setup_ph = psel && !penable;
    assign acc_ph = psel && penable;
    assign wr_acc = acc_ph && pwrite && mapped(paddr);
    assign head = s_q.rx[s_q.rx_rd];
    assign head_st = head[PS_LO +: 4];
    assign rx_nonempty = s_q.rx_cnt != '0;
    // Capacity is the smaller of the programmed depth and the store
    assign rx_full = (s_q.rx_cnt >= (RXW+1)'(RX_WORDS)) ||
                     ({1'b0, s_q.rx_depth} <= 11'(s_q.rx_cnt));
    assign xact_ev = ev_crc_err | ev_timeout | ev_stuff_err |
                     ev_false_eop;

    // Next state of everything
    always_comb begin
        logic [10:0] set_f;
        logic [10:0] clr_f;
        logic        rq_push;
        logic        rq_kind;
        logic        rq_pop;
        logic        rx_push;
        logic [31:0] rx_in;
        logic        rx_pop;
        logic [15:0] ep_set;
        set_f = '0;
        clr_f = '0;
        rq_push = 1'b0;
        rq_kind = REQ_IN;
        rq_pop = 1'b0;
        rx_push = 1'b0;
        rx_in = '0;
        rx_pop = 1'b0;
        ep_set = '0;
        s_d = s_q;
        s_d.tok = 1'b0;
        s_d.dis = 1'b0;
        s_d.nak = 1'b0;
        s_d.snd = 1'b0;

        // Response and error events, hardware sets only
        set_f[F_ACK] = ev_ack;
        set_f[F_NAK] = ev_nak;
        set_f[F_STALL] = ev_stall;
        set_f[F_BUS] = ev_bus_err;
        set_f[F_XACT] = xact_ev;
        set_f[F_BBL] = ev_babble;
        set_f[F_FOVR] = ev_frame_ovr;
        set_f[F_TGL] = ev_toggle;

        // APB setup: capture read data and response
        if (setup_ph) begin
            s_d.slverr = !mapped(paddr);
            s_d.rd_pop_ok = rx_nonempty;
            unique case (paddr)
                A_CORE_IRQ: s_d.rdata = ({31'h0, rx_nonempty} << G_RX_FIFO_LEVEL_IRQ)
                    | ({31'h0, |s_q.flags} << G_HCH);
                A_PEEK, A_POP:
                    s_d.rdata = rx_nonempty ? head : '0;
                A_RXFSIZE: s_d.rdata = {22'h0, s_q.rx_depth};
                A_ALLCH: s_d.rdata = {31'h0, |s_q.flags};
                A_HCCHAR: s_d.rdata = s_q.chr;
                A_HCINT: s_d.rdata = {21'h0, s_q.flags};
                A_EPFLAGS: s_d.rdata = {16'h0, s_q.ep_flags};
                default: s_d.rdata = '0;
            endcase
        end

        // APB access: writes and the popping read
        if (wr_acc) begin
            unique case (paddr)
                A_RXFSIZE: s_d.rx_depth = pwdata[9:0];
                A_HCINT: clr_f = pwdata[10:0] & F_MASK;
                A_EPFLAGS: s_d.ep_flags = s_q.ep_flags & ~pwdata[15:0];
                A_HCCHAR: begin
                    s_d.chr = {pwdata[31:30], 15'h0, pwdata[14:0]};
                    if (pwdata[C_DIS]) begin
                        rq_push = 1'b1;
                        rq_kind = REQ_DIS;
                        s_d.chr[C_EN] = 1'b0;
                        s_d.chr[C_DIS] = 1'b0;
                    end else if (pwdata[C_EN]) begin
                        rq_push = 1'b1;
                        rq_kind = REQ_IN;
                    end
                end
                default: ;
            endcase
        end
        if (acc_ph && !pwrite && paddr == A_POP && s_q.rd_pop_ok) begin
            rx_pop = 1'b1;
            set_f[F_XFER] = head_st == PS_XFER;
            set_f[F_HALT] = head_st == PS_HALT;
        end

        // Request queue head: IN waits out any OUT in flight
        if (s_q.rq_cnt != '0) begin
            if (s_q.rq[s_q.rq_rd] == REQ_DIS) begin
                if (!s_q.halt_pend) begin
                    rq_pop = 1'b1;
                    s_d.dis = 1'b1;
                    s_d.halt_pend = 1'b1;
                end
            end else if (!out_busy) begin
                rq_pop = 1'b1;
                s_d.tok = 1'b1;
            end
        end

        // Receive FIFO write: link packet first, halt entry after
        if (rx_wr && !rx_full) begin
            rx_push = 1'b1;
            rx_in = entry(rx_status, rx_pid, rx_byte_count_field, rx_id,
                          host_mode ? 4'h0 : rx_frame);
        end else if (s_q.halt_pend && !rx_full) begin
            rx_push = 1'b1;
            rx_in = entry(PS_HALT, 2'h0, 11'h0, 4'h0, 4'h0);
            s_d.halt_pend = 1'b0;
        end

        // Queue pointer upkeep; a full request queue drops the push
        if (rq_push && s_q.rq_cnt != (RQW+1)'(RQ_DEPTH)) begin
            s_d.rq[s_q.rq_wr] = rq_kind;
            s_d.rq_wr = s_q.rq_wr + 1'b1;
        end else begin
            rq_push = 1'b0;
        end
        if (rq_pop) begin
            s_d.rq_rd = s_q.rq_rd + 1'b1;
        end
        s_d.rq_cnt = s_q.rq_cnt + (RQW+1)'(rq_push) - (RQW+1)'(rq_pop);
        if (rx_push) begin
            s_d.rx[s_q.rx_wr] = rx_in;
            s_d.rx_wr = s_q.rx_wr + 1'b1;
        end
        if (rx_pop) begin
            s_d.rx_rd = s_q.rx_rd + 1'b1;
        end
        s_d.rx_cnt = s_q.rx_cnt + (RXW+1)'(rx_push) - (RXW+1)'(rx_pop);

        // Device IN token: NAK and flag when the FIFO is empty
        unique case (s_q.dst)
            D_IDLE: if (dev_in_token && !host_mode) begin
                if (!txf_has_data[dev_in_ep]) begin
                    s_d.nak = 1'b1;
                    ep_set[dev_in_ep] = 1'b1;
                end else begin
                    s_d.snd = 1'b1;
                    s_d.dst = D_WAIT;
                end
            end
            D_WAIT: if (dev_host_ack) begin
                s_d.dst = D_IDLE;
            end
        endcase

        // Set wins over a simultaneous write-one clear
        s_d.flags = ((s_q.flags & ~clr_f) | set_f) & F_MASK;
        s_d.ep_flags = s_d.ep_flags | ep_set;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.rx_depth <= RXDEP_RST;
            s_q.dst <= D_IDLE;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Zero wait state slave; data was captured in setup
    assign pready = psel && penable;
    assign prdata = s_q.rdata;
    assign pslverr = acc_ph && s_q.slverr;
    assign in_token_issue = s_q.tok;
    assign chan_disable_issue = s_q.dis;
    assign dev_nak = s_q.nak;
    assign dev_send = s_q.snd;
    assign dev_wait_ack = s_q.dst == D_WAIT;
    // Summaries are derived, so clearing flags clears the channel summary
    assign rx_fifo_level_irq = rx_nonempty;
    assign host_channels_summary_irq = |s_q.flags;

    // Checks
    property p_in_req;
        @(posedge mclk) disable iff (!resetn)
        clk_en && wr_acc && paddr == A_HCCHAR && pwpwdata_en_only()
        |=> s_q.rq_cnt != '0 || in_token_issue;
    endproperty
    function automatic logic pwpwdata_en_only();
        return pwdata[C_EN] && !pwdata[C_DIS] && s_q.rq_cnt == '0;
    endfunction
    a_in_req: assert property (p_in_req)
        else $error("enable did not queue IN request");

    property p_tok_out;
        @(posedge mclk) disable iff (!resetn)
        in_token_issue |-> !$past(out_busy);
    endproperty
    a_tok_out: assert property (p_tok_out)
        else $error("IN token issued during OUT");

    property p_rxlvl;
        @(posedge mclk) disable iff (!resetn)
        clk_en && rx_wr && !rx_full |=> rx_fifo_level_irq;
    endproperty
    a_rxlvl: assert property (p_rxlvl)
        else $error("level irq missing after packet");

    property p_xfer;
        @(posedge mclk) disable iff (!resetn)
        clk_en && acc_ph && !pwrite && paddr == A_POP && s_q.rd_pop_ok
        && head_st == PS_XFER |=> s_q.flags[F_XFER];
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("transfer complete not raised on pop");

    property p_halt_entry;
        @(posedge mclk) disable iff (!resetn)
        chan_disable_issue && !rx_full && clk_en && !rx_wr
        |=> rx_fifo_level_irq
        && s_q.rx[$past(s_q.rx_wr)][PS_LO +: 4] == PS_HALT;
    endproperty
    a_halt_entry: assert property (p_halt_entry)
        else $error("halt entry not written");

    property p_halted;
        @(posedge mclk) disable iff (!resetn)
        clk_en && acc_ph && !pwrite && paddr == A_POP && s_q.rd_pop_ok
        && head_st == PS_HALT |=> s_q.flags[F_HALT]
        && host_channels_summary_irq;
    endproperty
    a_halted: assert property (p_halted)
        else $error("halted flag not raised on pop");

    property p_nak;
        @(posedge mclk) disable iff (!resetn)
        clk_en && s_q.dst == D_IDLE && dev_in_token && !host_mode
        && !txf_has_data[dev_in_ep] |=> dev_nak && !dev_send
        && s_q.ep_flags[$past(dev_in_ep)];
    endproperty
    a_nak: assert property (p_nak)
        else $error("empty FIFO token not NAKed");

    property p_send;
        @(posedge mclk) disable iff (!resetn)
        dev_send |-> dev_wait_ack && !dev_nak;
    endproperty
    a_send: assert property (p_send)
        else $error("send without awaiting ACK");

    property p_setwins;
        @(posedge mclk) disable iff (!resetn)
        clk_en && ev_ack |=> s_q.flags[F_ACK];
    endproperty
    a_setwins: assert property (p_setwins)
        else $error("ACK flag lost");

    property p_peek;
        @(posedge mclk) disable iff (!resetn)
        clk_en && acc_ph && !pwrite && paddr == A_PEEK && !rx_wr
        && !s_q.halt_pend |=> s_q.rx_cnt == $past(s_q.rx_cnt);
    endproperty
    a_peek: assert property (p_peek)
        else $error("peek changed the FIFO");
endmodule
`default_nettype wire

// >>> verification/usb_far_model.sv
// Far-side USB model: status entries, link events, IN tokens
`timescale 1ns/1ps
`default_nettype none
module usb_far_model (
    // Clock
    input  wire logic        mclk,
    // Receive status entry
    output logic             rx_wr,
    output logic [3:0]       rx_status,
    output logic [1:0]       rx_pid,
    output logic [10:0]      rx_byte_count_field,
    output logic [3:0]       rx_id,
    output logic [3:0]       rx_frame,
    // Link events, one bit each
    output logic [10:0]      ev,
    // Device IN token side
    output logic             dev_in_token,
    output logic [3:0]       dev_in_ep,
    output logic             dev_host_ack
);
    // Quiet link at time zero
    initial begin
        rx_wr = 1'b0;
        {rx_status, rx_pid, rx_byte_count_field, rx_id, rx_frame} = 25'h0;
        ev = 11'h0;
        dev_in_token = 1'b0;
        dev_in_ep = 4'h0;
        dev_host_ack = 1'b0;
    end
    // One entry; fields scrambled afterwards so stale data never matches
    task automatic put(input logic [3:0] s, input logic [1:0] p,
                       input logic [10:0] b, input logic [3:0] i,
                       input logic [3:0] f);
        @(posedge mclk);
        rx_wr <= 1'b1;
        {rx_status, rx_pid, rx_byte_count_field, rx_id, rx_frame} <= {s, p, b, i, f};
        @(posedge mclk);
        rx_wr <= 1'b0;
        {rx_status, rx_pid, rx_byte_count_field, rx_id, rx_frame} <= ~{s, p, b, i, f};
    endtask
    // One-cycle event pulse on line k
    task automatic evt(input int k);
        @(posedge mclk);
        ev <= 11'h1 << k;
        @(posedge mclk);
        ev <= 11'h0;
    endtask
    // IN token towards one endpoint
    task automatic token(input logic [3:0] ep);
        @(posedge mclk);
        dev_in_token <= 1'b1;
        dev_in_ep <= ep;
        @(posedge mclk);
        dev_in_token <= 1'b0;
        dev_in_ep <= ~ep;
    endtask
    // Host handshake after a data packet
    task automatic ack();
        @(posedge mclk);
        dev_host_ack <= 1'b1;
        @(posedge mclk);
        dev_host_ack <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Bench for the channel queue, status FIFO and IN token block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import otg_rx_pkg::*;
    // Bench-driven inputs
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic        host_mode = 1'b1;
    logic        out_busy = 1'b0;
    logic [15:0] txf_has_data = 16'h0;
    // Design and partner outputs
    logic [31:0] prdata;
    logic        pready, pslverr, in_token_issue, chan_disable_issue;
    logic        dev_nak, dev_send, dev_wait_ack;
    logic        rx_fifo_level_irq, host_channels_summary_irq;
    logic        rx_wr, dev_in_token, dev_host_ack;
    logic [3:0]  rx_status, rx_id, rx_frame, dev_in_ep;
    logic [1:0]  rx_pid;
    logic [10:0] rx_byte_count_field, ev;
    // Bookkeeping
    int          bad_count = 0, compares = 0, cyc = 0;
    int          tok_n = 0, dis_n = 0, nak_n = 0, snd_n = 0;
    logic [31:0] rd, exp;
    logic        err_q;
    // Enable, endpoint 3, packet size 0x40
    localparam logic [31:0] CH_EN  = 32'h80001840;
    localparam logic [31:0] CH_DIS = 32'hc0001840;
    int fbit [11] = '{F_ACK, F_NAK, F_STALL, F_BUS, F_XACT, F_XACT,
                      F_XACT, F_XACT, F_BBL, F_FOVR, F_TGL};
    logic [3:0] codes [5] = '{PS_GLOBAL_OUT_NAK_STATUS, PS_PKT, PS_SETUP, PS_TGL,
                              PS_SETDATA};

    always #2.5 mclk = ~mclk;

    otg_rx_channel #(.RQ_DEPTH(4), .RX_WORDS(8)) dut (
        .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_mode(host_mode), .out_busy(out_busy),
        .in_token_issue(in_token_issue),
        .chan_disable_issue(chan_disable_issue), .rx_wr(rx_wr),
        .rx_status(rx_status), .rx_pid(rx_pid), .rx_byte_count_field(rx_byte_count_field),
        .rx_id(rx_id), .rx_frame(rx_frame), .ev_ack(ev[0]),
        .ev_nak(ev[1]), .ev_stall(ev[2]), .ev_bus_err(ev[3]),
        .ev_crc_err(ev[4]), .ev_timeout(ev[5]), .ev_stuff_err(ev[6]),
        .ev_false_eop(ev[7]), .ev_babble(ev[8]), .ev_frame_ovr(ev[9]),
        .ev_toggle(ev[10]), .dev_in_token(dev_in_token),
        .dev_in_ep(dev_in_ep), .txf_has_data(txf_has_data),
        .dev_host_ack(dev_host_ack), .dev_nak(dev_nak),
        .dev_send(dev_send), .dev_wait_ack(dev_wait_ack),
        .rx_fifo_level_irq(rx_fifo_level_irq),
        .host_channels_summary_irq(host_channels_summary_irq));

    usb_far_model far (
        .mclk(mclk), .rx_wr(rx_wr), .rx_status(rx_status),
        .rx_pid(rx_pid), .rx_byte_count_field(rx_byte_count_field), .rx_id(rx_id),
        .rx_frame(rx_frame), .ev(ev), .dev_in_token(dev_in_token),
        .dev_in_ep(dev_in_ep), .dev_host_ack(dev_host_ack));

    // Pulse counters; pulses last one cycle so each edge counts once
    always @(posedge mclk) begin
        if (in_token_issue === 1'b1) tok_n <= tok_n + 1;
        if (chan_disable_issue === 1'b1) dis_n <= dis_n + 1;
        if (dev_nak === 1'b1) nak_n <= nak_n + 1;
        if (dev_send === 1'b1) snd_n <= snd_n + 1;
    end
    // Hang guard, well beyond the few hundred cycles needed
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: saw %h, want %h",
                     $time, seen, want);
        end
    endtask
    // APB cycle: setup, access, hold until pready seen high
    task automatic apb(input logic w, input logic [17:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait a bounded time for a counter to move
    task automatic upto(ref int c, input int was);
        for (int k = 0; k < 30 && c == was; k++) @(posedge mclk);
    endtask
    function automatic logic [31:0] ent(input logic [3:0] f,
        input logic [3:0] s, input logic [1:0] p, input logic [10:0] b,
        input logic [3:0] i);
        return {7'h0, f, s, p, b, i};
    endfunction
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        // Reset values, depth field width, unmapped place
        apb(0, A_RXFSIZE, 0); chk(rd, 32'h200);
        apb(0, A_HCINT, 0); chk(rd, 0);
        apb(1, A_RXFSIZE, 32'hffffffff);
        apb(0, A_RXFSIZE, 0); chk(rd, 32'h3ff);
        apb(1, A_RXFSIZE, 32'h200);
        apb(0, 18'h3c0f0, 0); chk(err_q, 1); chk(rd, 0);
        // IN request held behind a running OUT
        out_busy <= 1'b1;
        apb(1, A_HCCHAR, CH_EN);
        apb(0, A_HCCHAR, 0); chk(rd & 32'h7fff, 32'h1840);
        repeat (8) @(posedge mclk);
        chk(tok_n, 0);
        out_busy <= 1'b0;
        upto(tok_n, 0); chk(tok_n, 1);
        // Host entry: level, peek keeps, pop removes
        far.put(PS_PKT, 2'h3, 11'h5a5, 4'h2, 4'h9);
        @(posedge mclk);
        chk(rx_fifo_level_irq, 1);
        apb(0, A_CORE_IRQ, 0); chk(rd[G_RX_FIFO_LEVEL_IRQ], 1);
        exp = ent(4'h0, PS_PKT, 2'h3, 11'h5a5, 4'h2);
        apb(0, A_PEEK, 0); chk(rd, exp);
        apb(0, A_PEEK, 0); chk(rd, exp);
        apb(0, A_POP, 0); chk(rd, exp);
        @(posedge mclk);
        chk(rx_fifo_level_irq, 0);
        // Completion entry, flag and both summaries
        far.put(PS_XFER, 2'h0, 11'h0, 4'h0, 4'h0);
        apb(0, A_POP, 0);
        apb(0, A_HCINT, 0); chk(rd[F_XFER], 1);
        apb(0, A_ALLCH, 0); chk(rd[0], 1);
        apb(0, A_CORE_IRQ, 0); chk(rd[G_HCH], 1);
        chk(host_channels_summary_irq, 1);
        apb(1, A_HCINT, 32'h1);
        apb(0, A_ALLCH, 0); chk(rd[0], 0);
        apb(0, A_CORE_IRQ, 0); chk(rd[G_HCH], 0);
        // Frozen clock enable: a status entry is ignored
        clk_en <= 1'b0;
        far.put(PS_PKT, 2'h0, 11'h1, 4'h1, 4'h0);
        @(posedge mclk);
        chk(rx_fifo_level_irq, 0);
        clk_en <= 1'b1;
        // Disable request, halt entry, halted flag
        apb(1, A_HCCHAR, CH_DIS);
        upto(dis_n, 0); chk(dis_n, 1);
        for (int k = 0; k < 20 && rx_fifo_level_irq !== 1'b1; k++)
            @(posedge mclk);
        chk(rx_fifo_level_irq, 1);
        apb(0, A_POP, 0); chk(rd[20:17], PS_HALT);
        apb(0, A_HCINT, 0); chk(rd[F_HALT], 1);
        apb(1, A_HCINT, 32'h2);
        apb(1, A_HCCHAR, 0);
        // Software cannot set flags; each event sets its bit, the four error causes share F_XACT
        apb(1, A_HCINT, 32'h7bf);
        apb(0, A_HCINT, 0); chk(rd, 0);
        for (int e = 0; e < 11; e++) begin
            far.evt(e);
            apb(0, A_HCINT, 0); chk(rd, 32'h1 << fbit[e]);
            apb(1, A_HCINT, 0);
            apb(0, A_HCINT, 0); chk(rd, 32'h1 << fbit[e]);
            apb(1, A_HCINT, 32'h1 << fbit[e]);
            apb(0, A_HCINT, 0); chk(rd, 0);
        end
        // Device entries: every listed code, PID and frame bits
        host_mode <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            far.put(codes[c], c[1:0], 11'(7 * c + 1), 4'(c), 4'(c + 10));
            exp = ent(4'(c + 10), codes[c], c[1:0], 11'(7 * c + 1), 4'(c));
            apb(0, A_POP, 0); chk(rd, exp);
        end
        // IN token on an empty, then a loaded, transmit FIFO
        far.token(4'h1);
        upto(nak_n, 0); chk(nak_n, 1); chk(snd_n, 0);
        apb(0, A_EPFLAGS, 0); chk(rd, 32'h2);
        apb(1, A_EPFLAGS, 32'h2);
        apb(0, A_EPFLAGS, 0); chk(rd, 0);
        txf_has_data <= 16'h0002;
        far.token(4'h1);
        upto(snd_n, 0); chk(snd_n, 1);
        @(posedge mclk);
        chk(dev_wait_ack, 1);
        far.ack();
        @(posedge mclk);
        chk(dev_wait_ack, 0);
        wrap_up();
    end
endmodule
`default_nettype wire
